// >>> cdab_pkg.sv
// shared constants and types for the charger detect alert bank
package cdab_pkg;

   // ==========================================
   // register offsets
   localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h30;
   localparam logic [7:0] ADDR_EVENT_MASKS = 8'h31;
   localparam logic [7:0] ADDR_RESULT_STATUS = 8'h32;
   localparam logic [7:0] ADDR_COMPARATOR_STATUS = 8'h33;
   localparam logic [7:0] ADDR_OVERVOLTAGE_STATUS = 8'h34;
   localparam logic [7:0] ADDR_CONTROL_PRIMARY = 8'h35;
   localparam logic [7:0] ADDR_CONTROL_LINE_DRIVE = 8'h36;
   localparam logic [7:0] ADDR_PORT_SWITCH = 8'h37;

   // ==========================================
   // alert bit positions
   localparam int BIT_LINE_OVERVOLTAGE = 6;
   localparam int BIT_MINUS_LINE_REF = 5;
   localparam int BIT_DETECT_ACTIVE_FALL = 4;
   localparam int BIT_DETECT_ACTIVE_RISE = 3;
   localparam int BIT_VENDOR_ADAPTER = 2;
   localparam int BIT_CONTACT_DETECT = 1;
   localparam int BIT_ADAPTER_CLASS = 0;
   localparam int ALERT_WIDTH = 7;

   // control and status field positions
   localparam int BIT_MANUAL_DETECT_REQUEST = 1;
   localparam int BIT_DETECT_ENABLE = 0;
   localparam int BIT_DETECT_ACTIVE = 6;

   // ==========================================
   // reset values
   localparam logic [6:0] RESET_FLAGS = 7'h00;
   localparam logic [6:0] RESET_MASKS = 7'h7F;
   localparam logic [7:0] RESET_CONTROL_PRIMARY = 8'h81;
   localparam logic [7:0] RESET_CONTROL_LINE_DRIVE = 8'h00;
   localparam logic [1:0] RESET_PORT_SWITCH = 2'h0;
   localparam logic [7:0] RW_MASK_PRIMARY = 8'hB3;
   localparam logic [7:0] RW_MASK_LINE_DRIVE = 8'hBF;

   // ==========================================
   // charger type encodings
   typedef enum logic [1:0] {
      CDAB_CLASS_NONE = 2'h0,
      CDAB_CLASS_SDP = 2'h1,
      CDAB_CLASS_CDP = 2'h2,
      CDAB_CLASS_DCP = 2'h3
   } cdab_class_e;

   // raw detection results from the analogue and sequencer side
   typedef struct packed {
      logic detect_active;
      logic [2:0] vendor_class;
      logic contact_timeout;
      cdab_class_e adapter_class;
      logic [7:0] comparator_bits;
      logic [1:0] overvoltage_bits;
   } cdab_status_s;

   // one-cycle event strobes from the detection logic
   typedef struct packed {
      logic minus_line_ref;
      logic vendor_adapter;
      logic contact_detect;
      logic adapter_class;
   } cdab_events_s;

   // register access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cdab_req_s;

endpackage

// >>> cdab_edge.sv
// synchroniser with rise and fall detection for one level
`timescale 1ns/1ns
module cdab_edge (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // level in
   input wire logic level_in,
   // synchronised level and edges
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } cdab_edge_s;

   cdab_edge_s st_q;
   cdab_edge_s st_d;

   always_comb begin
      st_d = st_q;
      st_d.meta = level_in;
      st_d.sync = st_q.meta;
      st_d.last = st_q.sync;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // edges look only at the second and third stages
   assign level_out = st_q.sync;
   assign rise_out = st_q.sync & ~st_q.last;
   assign fall_out = ~st_q.sync & st_q.last;
endmodule

// >>> cdab_flag.sv
// one sticky alert flag with clear-on-read
`timescale 1ns/1ns
module cdab_flag (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // event and clear
   input wire logic set_in,
   input wire logic clear_in,
   // flag
   output logic flag_out
);
   logic flag_q;
   logic flag_d;

   // set wins over a clear in the same cycle
   always_comb begin
      flag_d = flag_q;
      if (clear_in) begin
         flag_d = 1'b0;
      end
      if (set_in) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_out = flag_q;
endmodule

// >>> cdab_alert_bank.sv
// register bank and alert logic for charger port detection
`timescale 1ns/1ns

// How it works
// - alert bit 6 latches each new overvoltage event on either data line until the flags are read.
// - alert bit 5 latches each new minus-line reference comparator event until read.
// - alert bit 4 latches a falling edge of the detection-active status.
// - alert bit 3 latches a rising edge of the detection-active status.
// - alert bit 2 latches each new vendor adapter classification result.
// - alert bit 1 latches each new data-contact-detect event.
// - alert bit 0 latches each new charger-type result; all flags reset to 0 and any flag read clears all.
// - each mask bit 6..0 gates the flag at its position, 1 masking and 0 passing it.
// - all seven mask bits reset to 1.
// - flags sit at 0x30, masks 0x31, status at 0x32 and 0x33, overvoltage status at 0x34.
// - detection control at 0x35 and 0x36, port switch control at 0x37 with its field in bits 1..0.
// - the detection-active status bit reads 1 while detection runs, and its edges drive the alerts.
// - the charger type reads 0 none, 1 standard, 2 charging downstream, 3 dedicated charging.
// - writing 1 to the manual detection request starts one run once power is valid and self-clears.
module cdab_alert_bank (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // register access, same clock domain
   input wire cdab_pkg::cdab_req_s req_in,
   output logic [7:0] rdata_out,
   output logic rvalid_out,
   // detection side inputs
   input wire cdab_pkg::cdab_status_s status_in,
   input wire cdab_pkg::cdab_events_s events_in,
   input wire logic power_valid_in,
   // controls to the detection sequencer and switch
   output logic detect_enable_out,
   output logic manual_start_out,
   output logic [7:0] control_primary_out,
   output logic [7:0] control_line_drive_out,
   output logic [1:0] port_switch_select_out,
   // interrupt
   output logic irq_out
);
   // ==========================================
   // state
   typedef struct packed {
      logic [6:0] masks;
      logic [7:0] control_primary;
      logic [7:0] control_line_drive;
      logic [1:0] port_switch_select;
      logic manual_pending;
      logic manual_start;
      logic [7:0] rdata;
      logic rvalid;
      logic irq;
   } cdab_state_s;

   cdab_state_s st_q;
   cdab_state_s st_d;

   // ==========================================
   // overvoltage, detection-active and power-valid levels synchronised; event strobes used unsynchronised
   logic [1:0] ovp_sync;
   logic [1:0] ovp_rise;
   logic detect_active;
   logic active_rise;
   logic active_fall;
   logic power_valid;
   logic [6:0] flags;
   logic [6:0] set_vec;
   logic clear_all;
   logic flag_read;
   logic [7:0] result_status;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ovp
         cdab_edge u_ovp (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .level_in(status_in.overvoltage_bits[gi]),
            .level_out(ovp_sync[gi]),
            .rise_out(ovp_rise[gi]),
            .fall_out()
         );
      end
   endgenerate

   cdab_edge u_active (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .level_in(status_in.detect_active),
      .level_out(detect_active),
      .rise_out(active_rise),
      .fall_out(active_fall)
   );

   cdab_edge u_power (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .level_in(power_valid_in),
      .level_out(power_valid),
      .rise_out(),
      .fall_out()
   );

   // ==========================================
   // flag set sources
   always_comb begin
      set_vec = '0;
      set_vec[cdab_pkg::BIT_LINE_OVERVOLTAGE] = |ovp_rise;
      set_vec[cdab_pkg::BIT_MINUS_LINE_REF] = events_in.minus_line_ref;
      set_vec[cdab_pkg::BIT_DETECT_ACTIVE_FALL] = active_fall;
      set_vec[cdab_pkg::BIT_DETECT_ACTIVE_RISE] = active_rise;
      set_vec[cdab_pkg::BIT_VENDOR_ADAPTER] = events_in.vendor_adapter;
      set_vec[cdab_pkg::BIT_CONTACT_DETECT] = events_in.contact_detect;
      set_vec[cdab_pkg::BIT_ADAPTER_CLASS] = events_in.adapter_class;
   end

   // any read of the flag register clears all seven
   assign flag_read = req_in.rd && (req_in.addr == cdab_pkg::ADDR_EVENT_FLAGS);
   assign clear_all = flag_read;

   generate
      for (gi = 0; gi < cdab_pkg::ALERT_WIDTH; gi++) begin : g_flag
         cdab_flag u_flag (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .set_in(set_vec[gi]),
            .clear_in(clear_all),
            .flag_out(flags[gi])
         );
      end
   endgenerate

   // ==========================================
   // result status assembly, live values
   always_comb begin
      result_status = '0;
      result_status[cdab_pkg::BIT_DETECT_ACTIVE] = detect_active;
      result_status[5:3] = status_in.vendor_class;
      result_status[2] = status_in.contact_timeout;
      result_status[1:0] = status_in.adapter_class;
   end

   // ==========================================
   // next state
   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      st_d.manual_start = 1'b0;
      if (req_in.wr) begin
         unique case (req_in.addr)
            cdab_pkg::ADDR_EVENT_MASKS: begin
               st_d.masks = req_in.wdata[6:0];
            end
            cdab_pkg::ADDR_CONTROL_PRIMARY: begin
               st_d.control_primary = req_in.wdata & cdab_pkg::RW_MASK_PRIMARY;
               if (req_in.wdata[cdab_pkg::BIT_MANUAL_DETECT_REQUEST]) begin
                  st_d.manual_pending = 1'b1;
               end
            end
            cdab_pkg::ADDR_CONTROL_LINE_DRIVE: begin
               st_d.control_line_drive = req_in.wdata & cdab_pkg::RW_MASK_LINE_DRIVE;
            end
            cdab_pkg::ADDR_PORT_SWITCH: begin
               st_d.port_switch_select = req_in.wdata[1:0];
            end
            default: begin
            end
         endcase
      end
      // request fires one run once power is valid, then returns to 0
      if (st_q.manual_pending && power_valid) begin
         st_d.manual_pending = 1'b0;
         st_d.manual_start = 1'b1;
      end
      st_d.control_primary[cdab_pkg::BIT_MANUAL_DETECT_REQUEST] = st_d.manual_pending;
      if (req_in.rd) begin
         st_d.rvalid = 1'b1;
         unique case (req_in.addr)
            cdab_pkg::ADDR_EVENT_FLAGS: st_d.rdata = {1'b0, flags};
            cdab_pkg::ADDR_EVENT_MASKS: st_d.rdata = {1'b0, st_q.masks};
            cdab_pkg::ADDR_RESULT_STATUS: st_d.rdata = result_status;
            cdab_pkg::ADDR_COMPARATOR_STATUS: begin
               st_d.rdata = status_in.comparator_bits & 8'hBB;
            end
            cdab_pkg::ADDR_OVERVOLTAGE_STATUS: st_d.rdata = {6'h00, ovp_sync};
            cdab_pkg::ADDR_CONTROL_PRIMARY: st_d.rdata = st_q.control_primary;
            cdab_pkg::ADDR_CONTROL_LINE_DRIVE: st_d.rdata = st_q.control_line_drive;
            cdab_pkg::ADDR_PORT_SWITCH: st_d.rdata = {6'h00, st_q.port_switch_select};
            default: st_d.rdata = 8'h00;
         endcase
      end
      // a read clears flags next edge, so drop the line with them unless a new event lands
      st_d.irq = |((clear_all ? 7'h00 : flags) & ~st_d.masks | set_vec & ~st_d.masks);
   end

   // ==========================================
   // registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_q <= '0;
         st_q.masks <= cdab_pkg::RESET_MASKS;
         st_q.control_primary <= cdab_pkg::RESET_CONTROL_PRIMARY;
         st_q.control_line_drive <= cdab_pkg::RESET_CONTROL_LINE_DRIVE;
         st_q.port_switch_select <= cdab_pkg::RESET_PORT_SWITCH;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // outputs
   assign rdata_out = st_q.rdata;
   assign rvalid_out = st_q.rvalid;
   assign detect_enable_out = st_q.control_primary[cdab_pkg::BIT_DETECT_ENABLE];
   assign manual_start_out = st_q.manual_start;
   assign control_primary_out = st_q.control_primary;
   assign control_line_drive_out = st_q.control_line_drive;
   assign port_switch_select_out = st_q.port_switch_select;
   assign irq_out = st_q.irq;
endmodule

// >>> cdab_host.sv
// host processor model issuing single-byte register accesses
`timescale 1ns/1ns
module cdab_host (
   // clock and answer
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in,
   // request
   output cdab_pkg::cdab_req_s req_out
);
   // ==========================================
   // access task
   initial req_out = '0;
   // request held across one rising edge, then released to idle
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(negedge clk_in);
      req_out = {~wr, wr, a, d};
      @(negedge clk_in);
      req_out = '0;
      q = rvalid_in ? rdata_in : 8'hXX;
   endtask
endmodule

// >>> cdab_checker.sv
// port assertions for the charger detect alert bank
`timescale 1ns/1ns
module cdab_checker (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // inputs
   input wire cdab_pkg::cdab_req_s req_in,
   input wire cdab_pkg::cdab_status_s status_in,
   input wire cdab_pkg::cdab_events_s events_in,
   input wire logic power_valid_in,
   // outputs
   input wire logic [7:0] rdata_out,
   input wire logic rvalid_out,
   input wire logic detect_enable_out,
   input wire logic manual_start_out,
   input wire logic [7:0] control_primary_out,
   input wire logic [7:0] control_line_drive_out,
   input wire logic [1:0] port_switch_select_out,
   input wire logic irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire logic rd_flags = req_in.rd && req_in.addr == cdab_pkg::ADDR_EVENT_FLAGS;
   wire logic wr_ctl = req_in.wr && req_in.addr == cdab_pkg::ADDR_CONTROL_PRIMARY;
   // ==========================================
   // assertions
   chk_read_answer: assert property (req_in.rd |=> rvalid_out)
      else $error("read without answer");
   chk_no_stray: assert property (!req_in.rd |=> !rvalid_out)
      else $error("answer without read");
   chk_unmapped_zero: assert property (req_in.rd && (req_in.addr < 8'h30 ||
      req_in.addr > 8'h37) |=> rdata_out == 8'h00) else $error("unmapped read not zero");
   // async inputs need three quiet edges before a read is sure to clear everything
   chk_read_clears: assert property (rd_flags && events_in == '0 &&
      status_in == $past(status_in) && status_in == $past(status_in, 2) &&
      status_in == $past(status_in, 3) && !$past(reset_in) && !$past(reset_in, 2) &&
      !$past(reset_in, 3) |=> !irq_out) else $error("irq kept after read");
   // a mask write may legally drop the line as well
   chk_irq_holds: assert property (irq_out && !rd_flags &&
      !(req_in.wr && req_in.addr == cdab_pkg::ADDR_EVENT_MASKS) |=> irq_out)
      else $error("irq dropped without read");
   chk_drive_write: assert property (req_in.wr &&
      req_in.addr == cdab_pkg::ADDR_CONTROL_LINE_DRIVE |=> control_line_drive_out ==
      ($past(req_in.wdata) & cdab_pkg::RW_MASK_LINE_DRIVE)) else $error("line drive wrong");
   chk_switch_write: assert property (req_in.wr &&
      req_in.addr == cdab_pkg::ADDR_PORT_SWITCH |=> port_switch_select_out ==
      $past(req_in.wdata[1:0])) else $error("switch select wrong");
   chk_start_pulse: assert property (manual_start_out |=> !manual_start_out)
      else $error("start pulse too long");
   chk_manual_start: assert property (wr_ctl && req_in.wdata[1] && power_valid_in &&
      $past(power_valid_in, 3) && $past(power_valid_in, 2) && $past(power_valid_in) &&
      !$past(reset_in, 3) && !$past(reset_in, 2) && !$past(reset_in)
      |-> ##2 manual_start_out) else $error("manual start missing");
   chk_reset_state: assert property (disable iff (1'b0) reset_in |=> detect_enable_out &&
      control_primary_out == cdab_pkg::RESET_CONTROL_PRIMARY && !irq_out && !rvalid_out &&
      control_line_drive_out == 8'h00 && port_switch_select_out == 2'h0)
      else $error("reset state wrong");
   cov_irq: cover property (irq_out);
   cov_start: cover property (manual_start_out);
   cov_flags_read: cover property (rd_flags && irq_out);
endmodule
bind cdab_alert_bank cdab_checker chk (.clk_in(clk_in), .reset_in(reset_in), .req_in(req_in),
   .status_in(status_in), .events_in(events_in), .power_valid_in(power_valid_in),
   .rdata_out(rdata_out), .rvalid_out(rvalid_out), .detect_enable_out(detect_enable_out),
   .manual_start_out(manual_start_out), .control_primary_out(control_primary_out),
   .control_line_drive_out(control_line_drive_out),
   .port_switch_select_out(port_switch_select_out), .irq_out(irq_out));

// >>> charger_detect_alert_bank_test.sv
// self-checking bench for the charger detect alert bank
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("unexpected at %0t got %h want %h", $time, a, b); end end
module charger_detect_alert_bank_test;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic power_valid_in = 1'b1;
   cdab_pkg::cdab_status_s status_in = '0;
   cdab_pkg::cdab_events_s events_in = '0;
   cdab_pkg::cdab_req_s req;
   logic [7:0] rdata, ctl_p, ctl_l, q;
   logic rvalid, den, mstart, irq;
   logic [1:0] sw;
   int error_cnt = 0;
   int num_checks = 0;
   int cycles = 0;
   // rows: write flag, address, write data, expected read
   logic [24:0] rows [13] = '{{1'b0, 24'h300000}, {1'b0, 24'h31007F}, {1'b0, 24'h320000},
      {1'b0, 24'h330000}, {1'b0, 24'h340000}, {1'b0, 24'h350081}, {1'b0, 24'h360000},
      {1'b0, 24'h370000}, {1'b0, 24'h500000}, {1'b1, 24'h37FF00}, {1'b1, 24'h36FF00},
      {1'b1, 24'h30FF00}, {1'b1, 24'h310000}};
   logic [7:0] ev_exp [4] = '{8'h01, 8'h02, 8'h04, 8'h20};
   cdab_host h (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
   cdab_alert_bank dut (.clk_in(clk_in), .reset_in(reset_in), .req_in(req), .rdata_out(rdata),
      .rvalid_out(rvalid), .status_in(status_in), .events_in(events_in),
      .power_valid_in(power_valid_in), .detect_enable_out(den), .manual_start_out(mstart),
      .control_primary_out(ctl_p), .control_line_drive_out(ctl_l),
      .port_switch_select_out(sw), .irq_out(irq));
   // ==========================================
   // clock, timeout and verdict
   initial forever #10 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] a, output logic [7:0] d);
      h.access(1'b0, a, 8'h00, d);
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (20) @(negedge clk_in);
      reset_in = 1'b0;
      for (int i = 0; i < 13; i++) begin
         h.access(rows[i][24], rows[i][23:16], rows[i][15:8], q);
         if (!rows[i][24]) `CHK(q, rows[i][7:0])
      end
      rd_chk(8'h37, q);
      `CHK(q, 8'h03)
      `CHK(sw, 2'h3)
      `CHK(ctl_l, 8'hBF)
      $display("test table done");
      // masks now all clear, so each event must reach irq
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_in);
         events_in = cdab_pkg::cdab_events_s'(4'h1 << i);
         @(negedge clk_in);
         events_in = '0;
         `CHK(irq, 1'b1)
         rd_chk(8'h30, q);
         `CHK(q, ev_exp[i])
         `CHK(irq, 1'b0)
      end
      $display("test events done");
      status_in.detect_active = 1'b1;
      repeat (5) @(negedge clk_in);
      rd_chk(8'h32, q);
      `CHK(q, 8'h40)
      rd_chk(8'h30, q);
      `CHK(q, 8'h08)
      status_in.detect_active = 1'b0;
      status_in.overvoltage_bits = 2'h2;
      repeat (5) @(negedge clk_in);
      rd_chk(8'h34, q);
      `CHK(q, 8'h02)
      rd_chk(8'h30, q);
      `CHK(q, 8'h50)
      rd_chk(8'h30, q);
      `CHK(q, 8'h00)
      for (int k = 0; k < 4; k++) begin
         status_in.adapter_class = cdab_pkg::cdab_class_e'(k);
         rd_chk(8'h32, q);
         `CHK(q, 8'(k))
      end
      $display("test status done");
      // masked flag must still latch but stay off irq
      h.access(1'b1, 8'h31, 8'h7F, q);
      @(negedge clk_in);
      events_in.adapter_class = 1'b1;
      @(negedge clk_in);
      events_in = '0;
      `CHK(irq, 1'b0)
      rd_chk(8'h30, q);
      `CHK(q, 8'h01)
      // an event in the same cycle as a clearing read must survive it
      fork
         rd_chk(8'h30, q);
         begin
            @(negedge clk_in);
            events_in.adapter_class = 1'b1;
            @(negedge clk_in);
            events_in = '0;
         end
      join
      `CHK(q, 8'h00)
      rd_chk(8'h30, q);
      `CHK(q, 8'h01)
      // without power the request waits and reads back as pending
      power_valid_in = 1'b0;
      repeat (3) @(negedge clk_in);
      h.access(1'b1, 8'h35, 8'h83, q);
      repeat (3) @(negedge clk_in);
      `CHK(mstart, 1'b0)
      rd_chk(8'h35, q);
      `CHK(q, 8'h83)
      power_valid_in = 1'b1;
      for (int n = 0; n < 10 && mstart !== 1'b1; n++) @(negedge clk_in);
      `CHK(mstart, 1'b1)
      h.access(1'b1, 8'h35, 8'h83, q);
      for (int n = 0; n < 10 && mstart !== 1'b1; n++) @(negedge clk_in);
      `CHK(mstart, 1'b1)
      rd_chk(8'h35, q);
      `CHK(q, 8'h81)
      h.access(1'b1, 8'h35, 8'h00, q);
      `CHK(den, 1'b0)
      `CHK(ctl_p, 8'h00)
      $display("test mask and manual done");
      // leave non-reset values behind so the reset has something to undo
      h.access(1'b1, 8'h31, 8'h00, q);
      status_in = '0;
      reset_in = 1'b1;
      repeat (2) @(negedge clk_in);
      reset_in = 1'b0;
      `CHK(den, 1'b1)
      `CHK(ctl_p, 8'h81)
      `CHK(ctl_l, 8'h00)
      `CHK(irq, 1'b0)
      rd_chk(8'h31, q);
      `CHK(q, 8'h7F)
      `CHK(sw, 2'h0)
      $display("test second reset done");
      close_out();
   end
endmodule
